// ### core/lfwd_core.sv
// lfwd_core: wake-up pattern detector, apb register slave, listen timing and host wake.
// assumes lf_carrier and lf_data come demodulated from the receive front end,
// already synchronous to pclk.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lfwd_core #(
   parameter int WIN_STEP = lfwd_pkg::WIN_STEP_CYC,
   parameter int AMP_SETUP = lfwd_pkg::AMP_SETUP_CYC,
   parameter int SLOW_BASE = lfwd_pkg::SLOW_CYC,
   parameter int SLOW_TRIM = lfwd_pkg::SLOW_TRIM_CYC,
   parameter int RUN_MAX = lfwd_pkg::RUN_MAX_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lfwd_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lf_carrier,
   input wire logic lf_data,
   output logic rx_power_en,
   output logic host_wake
);
   import lfwd_pkg::*;

   typedef struct packed {
      lfwd_state_e state;
      logic [31:0] tmr;
      logic [TW-1:0] run;
      logic [TW-1:0] refw;
      logic [5:0] cnt;
      logic [TW-1:0] tbit;
      logic [TW-1:0] hc;
      logic [31:0] shreg;
      logic prev;
      logic wake;
      logic rx_on;
      logic [7:0] interval;
      logic [3:0] trim;
      logic [2:0] div;
      lfwd_proto_e proto;
      lfwd_wake_e wakept;
      logic wake_pre;
      logic [2:0] winsel;
      logic [17:0] sync;
      logic [15:0] wakeid;
      logic [7:0] data;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lfwd_regs_s;

   lfwd_regs_s s_r;
   lfwd_regs_s s_nxt;

   // run length within a quarter of the reference counts as equal
   function automatic logic near(input logic [TW:0] a, input logic [TW:0] b);
      logic [TW:0] d;
      d = (a > b) ? a - b : b - a;
      return d <= (b >> 2);
   endfunction : near

   // manchester bit value is the level of its first half
   function automatic logic [15:0] firsts(input logic [31:0] v);
      logic [15:0] r;
      r = 16'h0;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[2*i+1];
      end
      return r;
   endfunction : firsts

   function automatic logic halves_ok(input logic [31:0] v, input int nbits);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 16; i++) begin
         if (i < nbits && v[2*i+1] == v[2*i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : halves_ok

   logic [7:0] idx;
   logic hit;
   logic [31:0] rmux;
   logic wr_go;
   logic rd_go;
   logic edge_seen;
   logic [31:0] ivl;
   logic [31:0] win;
   logic active;
   logic smp_go;
   logic [31:0] smp;
   logic [5:0] cnt_inc;

   always_comb begin
      s_nxt = s_r;
      idx = paddr[ADDR_W-1:2];
      hit = 1'b1;
      rmux = 32'h0;
      unique case (idx)
         IDX_INTERVAL: rmux = {24'h0, s_r.interval};
         IDX_SLOWOSC: rmux = {25'h0, s_r.div, s_r.trim};
         IDX_PROTO: rmux = {27'h0, s_r.wake_pre, s_r.wakept, s_r.proto};
         IDX_LIMITS: rmux = {29'h0, s_r.winsel};
         IDX_SYNC: rmux = {14'h0, s_r.sync};
         IDX_WAKEID: rmux = {16'h0, s_r.wakeid};
         IDX_DATA: rmux = {24'h0, s_r.data};
         IDX_STATUS: rmux = {s_r.tbit, 8'h0, 4'(s_r.state), 3'h0, s_r.wake};
         default: hit = 1'b0;
      endcase

      // one wait state: data prepared in the first access cycle, pready the next
      rd_go = psel && penable && !s_r.pready;
      wr_go = psel && penable && s_r.pready && pwrite;
      s_nxt.pready = rd_go;
      if (rd_go) begin
         s_nxt.prdata = pwrite ? 32'h0 : rmux;
         s_nxt.pslverr = !hit;
      end else begin
         s_nxt.pslverr = 1'b0;
      end
      if (wr_go) begin
         unique case (idx)
            IDX_INTERVAL: s_nxt.interval = pwdata[7:0];
            IDX_SLOWOSC: begin
               s_nxt.trim = pwdata[OSC_TRIM_LSB +: 4];
               s_nxt.div = pwdata[OSC_DIV_LSB +: 3];
            end
            IDX_PROTO: begin
               s_nxt.proto = lfwd_proto_e'(pwdata[PROTO_SEL_LSB +: 2]);
               s_nxt.wakept = lfwd_wake_e'(pwdata[PROTO_WAKE_LSB +: 2]);
               s_nxt.wake_pre = pwdata[PROTO_WAKEPRE_BIT];
            end
            IDX_LIMITS: s_nxt.winsel = pwdata[2:0];
            IDX_SYNC: s_nxt.sync = pwdata[17:0];
            IDX_WAKEID: s_nxt.wakeid = pwdata[15:0];
            IDX_DATA: s_nxt.data = pwdata[7:0];
            IDX_STATUS: if (pwdata[STAT_WAKE_BIT]) s_nxt.wake = 1'b0;
            default: s_nxt.wake = s_r.wake;
         endcase
      end

      // listen interval and window for the selected variant
      if (s_r.proto == PROTO_BURST) begin
         ivl = (32'(SLOW_BASE) + 32'(s_r.trim) * 32'(SLOW_TRIM)) * (32'(s_r.div) + 32'h1);
      end else begin
         // interval count straight in slow periods; keeping it short enough is software's job
         ivl = 32'(s_r.interval) * 32'(SLOW_BASE);
      end
      win = 32'(s_r.winsel) * 32'(WIN_STEP);
      if (s_r.proto == PROTO_BURST && win < 32'(AMP_SETUP)) begin
         win = 32'(AMP_SETUP);
      end
      active = (s_r.proto == PROTO_NOPRE) || (s_r.proto == PROTO_BURST);

      edge_seen = lf_data != s_r.prev;
      s_nxt.prev = lf_data;
      smp = {s_r.shreg[30:0], lf_data};
      cnt_inc = s_r.cnt + 6'h1;
      smp_go = 1'b0;

      // half-bit sampler resyncs on every edge, samples at a quarter bit
      if (edge_seen || s_r.hc == (s_r.tbit >> 1) - TW'(1)) begin
         s_nxt.hc = '0;
      end else begin
         s_nxt.hc = s_r.hc + TW'(1);
      end
      smp_go = !edge_seen && s_r.hc == (s_r.tbit >> 2);

      if (s_r.run != '1) begin
         s_nxt.run = s_r.run + TW'(1);
      end

      unique case (s_r.state)
         ST_SLEEP: begin
            s_nxt.rx_on = 1'b0;
            s_nxt.tmr = active ? s_r.tmr + 32'h1 : 32'h0;
            if (active && s_r.tmr + 32'h1 >= ivl) begin
               s_nxt.state = ST_LISTEN;
               s_nxt.tmr = 32'h0;
               s_nxt.rx_on = 1'b1;
            end
         end
         ST_LISTEN: begin
            s_nxt.tmr = s_r.tmr + 32'h1;
            if (lf_carrier) begin
               s_nxt.state = ST_PRE;
               s_nxt.cnt = 6'h0;
               s_nxt.run = '0;
            end else if (s_r.tmr + 32'h1 >= win) begin
               s_nxt.state = ST_SLEEP;
               s_nxt.tmr = 32'h0;
               s_nxt.rx_on = 1'b0;
            end
         end
         ST_PRE: begin
            if (edge_seen) begin
               // the edge cycle is the first cycle of the new run, so a half bit of n cycles counts n
               s_nxt.run = TW'(1);
               if (s_r.cnt == 6'h0) begin
                  s_nxt.cnt = 6'h1;
               end else if (s_r.cnt == 6'h1) begin
                  s_nxt.refw = s_r.run;
                  s_nxt.cnt = 6'h2;
               end else if (near({1'b0, s_r.run}, {1'b0, s_r.refw})
                  || (s_r.proto == PROTO_NOPRE && (near({1'b0, s_r.run}, {s_r.refw, 1'b0})
                  || near({s_r.run, 1'b0}, {1'b0, s_r.refw})))) begin
                  s_nxt.cnt = cnt_inc;
                  if (cnt_inc == 6'(PRE_RUNS + 1)) begin
                     s_nxt.cnt = 6'h0;
                     s_nxt.state = s_r.wake_pre ? ST_HOST : ST_MEAS;
                     s_nxt.wake = s_r.wake | s_r.wake_pre;
                  end
               end else begin
                  s_nxt.refw = s_r.run;
                  s_nxt.cnt = 6'h2;
               end
            end else if (32'(s_r.run) > 32'(RUN_MAX)) begin
               s_nxt.state = ST_SLEEP;
               s_nxt.tmr = 32'h0;
               s_nxt.rx_on = 1'b0;
            end
         end
         ST_MEAS: begin
            if (edge_seen) begin
               s_nxt.run = TW'(1);
               if (s_r.cnt == 6'h0) begin
                  s_nxt.refw = s_r.run;
                  s_nxt.cnt = 6'h1;
               end else begin
                  s_nxt.tbit = s_r.refw + s_r.run;
                  s_nxt.cnt = 6'h0;
                  s_nxt.state = ST_SYNC;
               end
            end else if (32'(s_r.run) > 32'(RUN_MAX)) begin
               s_nxt.state = ST_SLEEP;
               s_nxt.tmr = 32'h0;
               s_nxt.rx_on = 1'b0;
            end
         end
         ST_SYNC, ST_WID, ST_DATA: begin
            if (smp_go) begin
               s_nxt.shreg = smp;
               s_nxt.cnt = cnt_inc;
               if (s_r.state == ST_SYNC && cnt_inc == 6'(SYNC_HALVES)) begin
                  s_nxt.cnt = 6'h0;
                  if (smp[17:0] != s_r.sync) begin
                     s_nxt.state = ST_SLEEP;
                  end else if (s_r.wakept == WAKE_SYNC) begin
                     s_nxt.state = ST_HOST;
                  end else begin
                     s_nxt.state = ST_WID;
                  end
               end else if (s_r.state == ST_WID && cnt_inc == 6'(2 * WAKEID_BITS)) begin
                  s_nxt.cnt = 6'h0;
                  if (firsts(smp) != s_r.wakeid || !halves_ok(smp, WAKEID_BITS)) begin
                     s_nxt.state = ST_SLEEP;
                  end else if (s_r.wakept == WAKE_ID) begin
                     s_nxt.state = ST_HOST;
                  end else begin
                     s_nxt.state = ST_DATA;
                  end
               end else if (s_r.state == ST_DATA && cnt_inc == 6'(2 * DATA_BITS)) begin
                  s_nxt.cnt = 6'h0;
                  // wake point none: a full match still goes back to sleep silently
                  if (firsts({16'h0, smp[15:0]}) == {8'h0, s_r.data} && halves_ok({16'h0, smp[15:0]}, DATA_BITS)
                     && s_r.wakept == WAKE_DATA) begin
                     s_nxt.state = ST_HOST;
                  end else begin
                     s_nxt.state = ST_SLEEP;
                  end
               end
               if (s_nxt.state == ST_HOST) begin
                  s_nxt.wake = 1'b1;
               end else if (s_nxt.state == ST_SLEEP) begin
                  s_nxt.tmr = 32'h0;
                  s_nxt.rx_on = 1'b0;
               end
            end
         end
         ST_HOST: begin
            // receive path stays up for the host until it acknowledges the wake
            s_nxt.rx_on = 1'b1;
            if (!s_r.wake) begin
               s_nxt.state = ST_SLEEP;
               s_nxt.tmr = 32'h0;
               s_nxt.rx_on = 1'b0;
            end
         end
         default: begin
            s_nxt.state = ST_SLEEP;
            s_nxt.rx_on = 1'b0;
         end
      endcase

      // a new wake set in the same cycle as a software clear wins
      if (s_r.state != ST_HOST && s_nxt.state == ST_HOST) begin
         s_nxt.wake = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{state: ST_SLEEP, tmr: 32'h0, run: '0, refw: '0, cnt: 6'h0, tbit: '0, hc: '0,
                  shreg: 32'h0, prev: 1'b0, wake: 1'b0, rx_on: 1'b0, interval: RST_INTERVAL,
                  trim: RST_TRIM, div: RST_DIV, proto: PROTO_NOPRE, wakept: WAKE_NONE,
                  wake_pre: 1'b0, winsel: RST_WINSEL, sync: RST_SYNC, wakeid: RST_WAKEID,
                  data: RST_DATA, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign rx_power_en = s_r.rx_on;
   assign host_wake = s_r.wake;

endmodule : lfwd_core
`default_nettype wire

// ### include/lfwd_pkg.sv
// lfwd_pkg: register map, field layout, reset values, states and timing constants
// of the low-frequency wake-up pattern detector; shared by the core and its bench.
package lfwd_pkg;

   // register indices; byte address on apb is four times the index
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_INTERVAL = 8'hc4;
   localparam logic [7:0] IDX_SLOWOSC = 8'h97;
   localparam logic [7:0] IDX_PROTO = 8'ha4;
   localparam logic [7:0] IDX_LIMITS = 8'hdc;
   localparam logic [7:0] IDX_SYNC = 8'had;
   localparam logic [7:0] IDX_WAKEID = 8'haf;
   localparam logic [7:0] IDX_DATA = 8'hcc;
   localparam logic [7:0] IDX_STATUS = 8'he0;

   // field positions
   localparam int PROTO_SEL_LSB = 0;
   localparam int PROTO_WAKE_LSB = 2;
   localparam int PROTO_WAKEPRE_BIT = 4;
   localparam int OSC_TRIM_LSB = 0;
   localparam int OSC_DIV_LSB = 4;
   localparam int STAT_WAKE_BIT = 0;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_TBIT_LSB = 16;
   localparam int SYNC_HALVES = 18;
   localparam int WAKEID_BITS = 16;
   localparam int DATA_BITS = 8;
   localparam int PRE_RUNS = 5;

   // reset values
   localparam logic [7:0] RST_INTERVAL = 8'h01;
   localparam logic [3:0] RST_TRIM = 4'h8;
   localparam logic [2:0] RST_DIV = 3'h0;
   localparam logic [2:0] RST_WINSEL = 3'h1;
   localparam logic [17:0] RST_SYNC = 18'h0;
   localparam logic [15:0] RST_WAKEID = 16'h0;
   localparam logic [7:0] RST_DATA = 8'h0;

   typedef enum logic [1:0] {
      PROTO_PWM = 2'b00, PROTO_PREONLY = 2'b01, PROTO_NOPRE = 2'b10, PROTO_BURST = 2'b11
   } lfwd_proto_e;

   typedef enum logic [1:0] {
      WAKE_NONE = 2'b00, WAKE_SYNC = 2'b01, WAKE_ID = 2'b10, WAKE_DATA = 2'b11
   } lfwd_wake_e;

   typedef enum logic [3:0] {
      ST_SLEEP = 4'h0, ST_LISTEN = 4'h1, ST_PRE = 4'h2, ST_MEAS = 4'h3,
      ST_SYNC = 4'h4, ST_WID = 4'h5, ST_DATA = 4'h6, ST_HOST = 4'h7
   } lfwd_state_e;

   // timing
   localparam int CLK_NS = 20;
   localparam int TBIT_NOM_NS = 256000;
   localparam int LFOSC_NS = 3333;
   localparam int WIN_STEP_NS = 128 * 4 * LFOSC_NS;
   localparam int WIN_STEP_CYC = WIN_STEP_NS / CLK_NS;
   localparam int AMP_SETUP_NS = 150000;
   localparam int AMP_SETUP_CYC = (AMP_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOW_PERIOD_NS = 2222222;
   localparam int SLOW_CYC = SLOW_PERIOD_NS / CLK_NS;
   localparam int SLOW_TRIM_NS = 50000;
   localparam int SLOW_TRIM_CYC = SLOW_TRIM_NS / CLK_NS;
   localparam int RUN_MAX_CYC = 4 * TBIT_NOM_NS / CLK_NS;
   localparam int TW = 16;

endpackage : lfwd_pkg

// ### tb/lfwd_monitor.sv
// lfwd_monitor: port-level checks of the wake-up detector
// assumes the apb master holds each request until pready
`timescale 1ns/1ps
`default_nettype none
module lfwd_monitor #(
   parameter int WIN_STEP = 20,
   parameter int AMP_SETUP = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lfwd_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic lf_carrier,
   input wire logic lf_data,
   input wire logic rx_power_en,
   input wire logic host_wake
);
   import lfwd_pkg::*;
   logic [15:0] win_r;
   logic [7:0] edg_r;
   logic seen_r;
   logic dq_r;
   logic [7:0] ix;
   logic map;
   assign ix = paddr[9:2];
   assign map = ix inside {IDX_INTERVAL, IDX_SLOWOSC, IDX_PROTO, IDX_LIMITS, IDX_SYNC, IDX_WAKEID, IDX_DATA, IDX_STATUS};
   // edge count saturates so a long frame cannot wrap below the preamble figure
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_r <= 16'h0;
         edg_r <= 8'h0;
         seen_r <= 1'b0;
         dq_r <= 1'b0;
      end else begin
         dq_r <= lf_data;
         seen_r <= rx_power_en && (seen_r || lf_carrier);
         win_r <= rx_power_en ? win_r + 16'h1 : 16'h0;
         edg_r <= !rx_power_en ? 8'h0 : edg_r + {7'h0, lf_data != dq_r && edg_r != 8'hff};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (pready |-> pslverr == !map)
      else $error("pslverr does not follow the address map");
   a_rdata_zero: assert property (pready && (pwrite || !map) |-> prdata == 32'h0)
      else $error("prdata not zero on write or unmapped");
   a_window_bound: assert property (rx_power_en && !seen_r && !lf_carrier |-> win_r <= 7 * WIN_STEP + AMP_SETUP + 4)
      else $error("listen window without carrier too long");
   a_wake_sticky: assert property (host_wake && !(pready && pwrite && ix == IDX_STATUS && pwdata[0]) |=> host_wake)
      else $error("host wake dropped without clear");
   a_wake_edges: assert property ($rose(host_wake) |-> edg_r >= 8'd6)
      else $error("host woken before preamble edges");
   a_wake_powered: assert property ($rose(host_wake) |-> rx_power_en && seen_r)
      else $error("host woken without powered carrier");
   c_wake: cover property ($rose(host_wake));
   c_err: cover property (pready && pslverr);
   c_idle_listen: cover property ($fell(rx_power_en) && !seen_r);
endmodule : lfwd_monitor
bind lfwd_core lfwd_monitor #(.WIN_STEP(WIN_STEP), .AMP_SETUP(AMP_SETUP)) u_lfwd_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .lf_carrier(lf_carrier), .lf_data(lf_data), .rx_power_en(rx_power_en), .host_wake(host_wake)
);
`default_nettype wire

// ### tb/lfwd_tx_model.sv
// lfwd_tx_model: remote transmitter sending one manchester telegram per call
// assumes pclk from the bench; a frame starts as the receive path powers up
`timescale 1ns/1ps
`default_nettype none
module lfwd_tx_model (
   input wire logic pclk,
   input wire logic rx_power_en,
   output logic lf_carrier,
   output logic lf_data,
   output int pos
);
   // no carrier means the slicer output rests low
   initial begin
      lf_carrier = 1'b0;
      lf_data = 1'b0;
      pos = 0;
   end
   task automatic send(input logic [17:0] s, input logic [15:0] w, input logic [7:0] d, input int h);
      logic q[$];
      logic b;
      // six preamble edges, then two single halves for the bit period; the last half differs from sync bit 17
      q = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 17; i >= 0; i--) q.push_back(s[i]);
      for (int i = 23; i >= 0; i--) begin
         b = i > 7 ? w[i-8] : d[i];
         q.push_back(b);
         q.push_back(!b);
      end
      @(posedge rx_power_en);
      foreach (q[i]) begin
         lf_carrier <= 1'b1;
         lf_data <= q[i];
         pos <= i + 1;
         repeat (h) @(posedge pclk);
      end
      lf_carrier <= 1'b0;
      lf_data <= 1'b0;
   endtask : send
endmodule : lfwd_tx_model
`default_nettype wire

// ### tb/lfwd_core_tb.sv
// lfwd_core_tb: register, listen timing and telegram checks of the detector
// assumes shortened timing parameters; halves of H cycles stand for 128 us
`timescale 1ns/1ps
`default_nettype none
module lfwd_core_tb;
   import lfwd_pkg::*;
   localparam int H = 40;
   localparam logic [17:0] SY = 18'h0cb35;
   localparam logic [15:0] WI = 16'ha53c;
   localparam logic [7:0] DA = 8'h96;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lf_carrier, lf_data, rx_power_en, host_wake, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int mismatches, samples_checked, pos, hi, lo, slp;
   logic [7:0] rix [7] = '{IDX_INTERVAL, IDX_SLOWOSC, IDX_PROTO, IDX_LIMITS, IDX_SYNC, IDX_WAKEID, IDX_DATA};
   logic [31:0] rrv [7] = '{32'h01, 32'h08, 32'h02, 32'h01, 32'h0, 32'h0, 32'h0};
   logic [31:0] rmk [7] = '{32'hff, 32'h7f, 32'h1f, 32'h07, 32'h3ffff, 32'hffff, 32'hff};
   // protocol, interval, slow osc, window select, expected gap, expected window
   int tmv [2][6] = '{'{2, 3, 8'h13, 2, 90, 40}, '{3, 1, 8'h13, 0, 72, 10}};
   // protocol register, fault (1 id, 2 sync), halves sent at wake, wake expected
   int frm [8][4] = '{'{6, 0, 26, 1}, '{10, 0, 58, 1}, '{14, 0, 74, 1}, '{18, 0, 7, 1},
                      '{14, 1, 0, 0}, '{6, 2, 0, 0}, '{2, 0, 0, 0}, '{15, 0, 74, 1}};
   lfwd_core #(.WIN_STEP(20), .AMP_SETUP(10), .SLOW_BASE(30), .SLOW_TRIM(2), .RUN_MAX(400)) u_lfwd_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lf_carrier(lf_carrier),
      .lf_data(lf_data), .rx_power_en(rx_power_en), .host_wake(host_wake));
   lfwd_tx_model u_lfwd_tx_model (.pclk(pclk), .rx_power_en(rx_power_en), .lf_carrier(lf_carrier),
      .lf_data(lf_data), .pos(pos));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rst();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst
   // one window and the gap after it; the caller discards the first call
   task automatic meas();
      int n;
      n = 0;
      hi = 0;
      lo = 0;
      while (rx_power_en !== 1'b1 && n < 3000) begin @(negedge pclk); n++; end
      while (rx_power_en === 1'b1 && n < 3000) begin @(negedge pclk); n++; hi++; end
      while (rx_power_en !== 1'b1 && n < 3000) begin @(negedge pclk); n++; lo++; end
   endtask : meas
   initial begin
      repeat (60000) @(posedge pclk);
      mismatches++;
      conclude();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      mismatches = 0;
      samples_checked = 0;
      rst();
      for (int i = 0; i < 7; i++) begin
         apb(0, rix[i], 0);
         chk("reset value", rrv[i], rd);
         apb(1, rix[i], 32'hffffffff);
         apb(0, rix[i], 0);
         chk("field width", rmk[i], rd);
         apb(1, rix[i], rrv[i]);
      end
      apb(1, 8'h00, 32'h1);
      chk("unmapped error", 1, err);
      apb(0, 8'h00, 0);
      chk("unmapped data", 0, rd);
      $display("test registers done");
      for (int p = 0; p < 2; p++) begin
         rst();
         apb(1, IDX_PROTO, p);
         hi = 0;
         repeat (300) @(negedge pclk) if (rx_power_en !== 1'b0) hi++;
         chk("refused listen", 0, hi);
      end
      $display("test refused protocols done");
      for (int i = 0; i < 2; i++) begin
         rst();
         apb(1, IDX_INTERVAL, tmv[i][1]);
         apb(1, IDX_SLOWOSC, tmv[i][2]);
         apb(1, IDX_LIMITS, tmv[i][3]);
         apb(1, IDX_PROTO, tmv[i][0]);
         meas();
         meas();
         chk("listen window", 1, hi >= tmv[i][5] - 2 && hi <= tmv[i][5] + 2);
         chk("listen gap", 1, lo >= tmv[i][4] - 2 && lo <= tmv[i][4] + 2);
      end
      $display("test listen timing done");
      for (int i = 0; i < 8; i++) begin
         rst();
         apb(1, IDX_INTERVAL, 2);
         apb(1, IDX_SYNC, SY);
         apb(1, IDX_WAKEID, WI);
         apb(1, IDX_DATA, DA);
         apb(1, IDX_PROTO, frm[i][0]);
         fork
            u_lfwd_tx_model.send(frm[i][1] == 2 ? SY ^ 18'h1 : SY, frm[i][1] == 1 ? WI ^ 16'h1 : WI, DA, H);
         join_none
         hi = 0;
         slp = 0;
         while (host_wake !== 1'b1 && hi < 4000) begin
            @(negedge pclk);
            hi++;
            if (lf_carrier === 1'b1 && rx_power_en === 1'b0) slp++;
         end
         lo = pos;
         wait fork;
         chk("host woken", frm[i][3], host_wake);
         if (frm[i][3] == 1 || frm[i][1] != 0) chk("slept mid frame", frm[i][3] == 0, slp != 0);
         if (frm[i][3] == 1) begin
            chk("wake point", 1, lo >= frm[i][2] - 2 && lo <= frm[i][2] + 2);
            apb(0, IDX_STATUS, 0);
            chk("host state", ST_HOST, rd[7:4]);
            if (frm[i][2] > 7) chk("bit period", 2 * H, rd[31:16]);
            apb(1, IDX_STATUS, 1);
            @(negedge pclk);
            chk("wake cleared", 0, host_wake);
         end
      end
      $display("test telegrams done");
      conclude();
   end
endmodule : lfwd_core_tb
`default_nettype wire
